//--- inc/chxo_pkg.sv
package chxo_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [3:0]  ADDR_OUTBOUND = 4'h0;
  localparam logic [3:0]  ADDR_INBOUND  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;
  localparam logic [3:0]  ADDR_OUTPUTS  = 4'hC;
  // ==========================================
  // Widths
  localparam int NUM_OUT    = 4;
  localparam int NUM_IPR    = 8;
  localparam int CMD_W      = 8;
  localparam int DATA_W     = 24;
  // ==========================================
  // Command numbers
  localparam logic [7:0] CMD_DISCRETE   = 8'h00;
  localparam logic [7:0] CMD_RESET_CARD = 8'h01;
  localparam logic [7:0] CMD_CONTINUE   = 8'h02;
  localparam logic [7:0] CMD_RET_DISC   = 8'h03;
  localparam logic [7:0] CMD_RET_STATUS = 8'h07;
  localparam logic [7:0] CMD_RET_OUTS   = 8'h08;
  localparam logic [7:0] CMD_RET_COUNT  = 8'h09;
  localparam logic [7:0] CMD_RET_RATE   = 8'h0A;
  localparam logic [7:0] CMD_OUT_PRESET = 8'h10;
  localparam logic [7:0] CMD_INT_PRESET = 8'h18;
  localparam logic [7:0] CMD_SENSE      = 8'h23;
  // Preset command index field
  localparam int OPR_IDX_W = 2;
  localparam int IPR_IDX_W = 3;
  // ==========================================
  // Discrete command fields (word bit index = documented bit - 1)
  localparam int DISC_EN_LSB    = 10;
  localparam int DISC_LATCH_LSB = 14;
  // ==========================================
  // Inbound word tags and codes
  localparam logic [7:0]  TAG_STATUS = 8'h01;
  localparam logic [7:0]  TAG_OUTS   = 8'h02;
  localparam logic [7:0]  TAG_COUNT  = 8'h03;
  localparam logic [7:0]  TAG_RATE   = 8'h04;
  localparam logic [7:0]  TAG_DISC   = 8'h05;
  localparam logic [7:0]  TAG_ERROR  = 8'hFF;
  localparam logic [23:0] ERR_BAD_CMD = 24'h00_0001;
  localparam logic [23:0] ERR_LOCKED  = 24'h00_0002;
  // ==========================================
  // Status bits
  localparam int ST_RELOAD   = 0;
  localparam int ST_LOADED   = 1;
  localparam int ST_POWER_UP = 2;
  // ==========================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    chxo_ret_status = 3'b000,
    chxo_ret_outs   = 3'b001,
    chxo_ret_count  = 3'b010,
    chxo_ret_rate   = 3'b011,
    chxo_ret_disc   = 3'b100
  } chxo_ret_e;
endpackage : chxo_pkg

//--- src/chxo_top.sv
`timescale 1ns/100ps
`default_nettype none

module chxo_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Counter core
  input  wire logic [23:0] accum_count,
  input  wire logic [23:0] rate_value,
  // System conditions
  input  wire logic        power_lost,
  input  wire logic        host_online,
  input  wire logic        keep_running_jumper,
  // Field outputs and internal preset results
  output logic [3:0]       field_out,
  output logic [7:0]       preset_hit
);

  // ==========================================
  // Comparison helper
  function automatic logic cmp_result(input logic [23:0] count,
                                      input logic [23:0] preset,
                                      input logic        sense);
    logic ge;
    ge = $signed(count) >= $signed(preset);
    cmp_result = sense ? ge : ~ge;
  endfunction : cmp_result

  // ==========================================
  // State
  logic [23:0]          out_preset [chxo_pkg::NUM_OUT];
  logic [23:0]          int_preset [chxo_pkg::NUM_IPR];
  logic [3:0]           out_sense;
  logic [7:0]           int_sense;
  logic [3:0]           out_enable;
  logic [3:0]           latch_req;
  logic [23:0]          last_disc;
  logic [31:0]          inbound;
  logic [31:0]          outbound;
  logic                 wr_commit;
  chxo_pkg::chxo_ret_e  ret_sel;
  logic [2:0]           status;
  logic                 aw_got;
  logic                 w_got;
  logic [3:0]           aw_addr;
  logic [31:0]          w_data;
  logic                 scan;
  logic [7:0]           cmd;
  logic [23:0]          pay;
  logic [3:0]           next_out;
  logic [7:0]           next_hit;
  logic                 run_ok;

  assign cmd = w_data[7:0];
  assign pay = w_data[31:8];
  // One outbound word per completed write to the exchange address
  assign wr_commit = aw_got && w_got && !s_axi_bvalid;
  assign scan = wr_commit && aw_addr == chxo_pkg::ADDR_OUTBOUND;

  // ==========================================
  // AXI write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      aw_addr       <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got        <= 1'b0;
      w_data       <= 32'h0000_0000;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_got && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
      end else if (aw_got && w_got && !s_axi_bvalid) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= chxo_pkg::RESP_OKAY;
    end else if (aw_got && w_got && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == chxo_pkg::ADDR_OUTBOUND ||
                       aw_addr == chxo_pkg::ADDR_STATUS)
                      ? chxo_pkg::RESP_OKAY : chxo_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= chxo_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= chxo_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          chxo_pkg::ADDR_OUTBOUND: s_axi_rdata <= outbound;
          chxo_pkg::ADDR_INBOUND:  s_axi_rdata <= inbound;
          chxo_pkg::ADDR_STATUS:   s_axi_rdata <= {29'h000_0000, status};
          chxo_pkg::ADDR_OUTPUTS:  s_axi_rdata <= {20'h0_0000, preset_hit, field_out};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= chxo_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Command execution: presets, sense, discrete bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < chxo_pkg::NUM_OUT; i++) out_preset[i] <= 24'h00_0000;
      for (int i = 0; i < chxo_pkg::NUM_IPR; i++) int_preset[i] <= 24'h00_0000;
      out_sense  <= 4'h0;
      int_sense  <= 8'h00;
      out_enable <= 4'h0;
      latch_req  <= 4'h0;
      last_disc  <= 24'h00_0000;
    end else if (scan && !status[chxo_pkg::ST_POWER_UP]) begin
      if (cmd == chxo_pkg::CMD_DISCRETE) begin
        last_disc  <= pay;
        out_enable <= w_data[chxo_pkg::DISC_EN_LSB +: chxo_pkg::NUM_OUT];
        latch_req  <= w_data[chxo_pkg::DISC_LATCH_LSB +: chxo_pkg::NUM_OUT];
      end else if (cmd == chxo_pkg::CMD_SENSE) begin
        out_sense <= pay[chxo_pkg::NUM_OUT-1:0];
        int_sense <= pay[chxo_pkg::NUM_OUT +: chxo_pkg::NUM_IPR];
      end else if (cmd[7:chxo_pkg::OPR_IDX_W] ==
                   chxo_pkg::CMD_OUT_PRESET[7:chxo_pkg::OPR_IDX_W]) begin
        out_preset[cmd[chxo_pkg::OPR_IDX_W-1:0]] <= pay;
      end else if (cmd[7:chxo_pkg::IPR_IDX_W] ==
                   chxo_pkg::CMD_INT_PRESET[7:chxo_pkg::IPR_IDX_W]) begin
        int_preset[cmd[chxo_pkg::IPR_IDX_W-1:0]] <= pay;
      end else if (cmd == chxo_pkg::CMD_RESET_CARD) begin
        for (int i = 0; i < chxo_pkg::NUM_OUT; i++) out_preset[i] <= 24'h00_0000;
        for (int i = 0; i < chxo_pkg::NUM_IPR; i++) int_preset[i] <= 24'h00_0000;
        out_sense  <= 4'h0;
        int_sense  <= 8'h00;
        out_enable <= 4'h0;
        latch_req  <= 4'h0;
        last_disc  <= 24'h00_0000;
      end
    end else if (scan && cmd == chxo_pkg::CMD_RESET_CARD) begin
      for (int i = 0; i < chxo_pkg::NUM_OUT; i++) out_preset[i] <= 24'h00_0000;
      for (int i = 0; i < chxo_pkg::NUM_IPR; i++) int_preset[i] <= 24'h00_0000;
      latch_req <= 4'h0;
    end
  end

  // ==========================================
  // Status: reload flag, presets loaded, power-up lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 3'b000;
    end else begin
      // Power loss sets; a clear in the same cycle loses
      if (power_lost) begin
        status[chxo_pkg::ST_RELOAD] <= 1'b1;
      end else if (scan && cmd[7:chxo_pkg::IPR_IDX_W] ==
                   chxo_pkg::CMD_INT_PRESET[7:chxo_pkg::IPR_IDX_W]) begin
        status[chxo_pkg::ST_RELOAD] <= 1'b0;
      end
      if (power_lost || (scan && cmd == chxo_pkg::CMD_RESET_CARD)) begin
        status[chxo_pkg::ST_LOADED] <= 1'b0;
      end else if (scan && !status[chxo_pkg::ST_POWER_UP] &&
                   cmd[7:chxo_pkg::OPR_IDX_W] ==
                   chxo_pkg::CMD_OUT_PRESET[7:chxo_pkg::OPR_IDX_W]) begin
        status[chxo_pkg::ST_LOADED] <= 1'b1;
      end
      if (scan && cmd == chxo_pkg::CMD_RESET_CARD) begin
        status[chxo_pkg::ST_POWER_UP] <= 1'b1;
      end else if (wr_commit && w_data[chxo_pkg::ST_POWER_UP] == 1'b0 &&
                   aw_addr == chxo_pkg::ADDR_STATUS) begin
        status[chxo_pkg::ST_POWER_UP] <= 1'b0;
      end
    end
  end

  // Last outbound word, kept apart from writes to other addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outbound <= 32'h0000_0000;
    end else if (scan) begin
      outbound <= w_data;
    end
  end

  // ==========================================
  // Return-data selection and inbound word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ret_sel <= chxo_pkg::chxo_ret_status;
    end else if (scan && !status[chxo_pkg::ST_POWER_UP]) begin
      unique case (cmd)
        chxo_pkg::CMD_RET_STATUS: ret_sel <= chxo_pkg::chxo_ret_status;
        chxo_pkg::CMD_RET_OUTS:   ret_sel <= chxo_pkg::chxo_ret_outs;
        chxo_pkg::CMD_RET_COUNT:  ret_sel <= chxo_pkg::chxo_ret_count;
        chxo_pkg::CMD_RET_RATE:   ret_sel <= chxo_pkg::chxo_ret_rate;
        chxo_pkg::CMD_RET_DISC:   ret_sel <= chxo_pkg::chxo_ret_disc;
        default:                  ret_sel <= ret_sel;
      endcase
    end
  end

  function automatic logic [31:0] ret_word(input chxo_pkg::chxo_ret_e sel);
    unique case (sel)
      chxo_pkg::chxo_ret_status:
        ret_word = {chxo_pkg::TAG_STATUS, 21'h0_0000, status};
      chxo_pkg::chxo_ret_outs:
        ret_word = {chxo_pkg::TAG_OUTS, 12'h000, preset_hit, field_out};
      chxo_pkg::chxo_ret_count:
        ret_word = {chxo_pkg::TAG_COUNT, accum_count};
      chxo_pkg::chxo_ret_rate:
        ret_word = {chxo_pkg::TAG_RATE, rate_value};
      chxo_pkg::chxo_ret_disc:
        ret_word = {chxo_pkg::TAG_DISC, last_disc};
      default:
        ret_word = {chxo_pkg::TAG_ERROR, chxo_pkg::ERR_BAD_CMD};
    endcase
  endfunction : ret_word

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = c <= chxo_pkg::CMD_RET_DISC || c == chxo_pkg::CMD_SENSE
             || (c >= chxo_pkg::CMD_RET_STATUS && c <= chxo_pkg::CMD_RET_RATE)
             || (c[7:chxo_pkg::OPR_IDX_W] ==
                 chxo_pkg::CMD_OUT_PRESET[7:chxo_pkg::OPR_IDX_W])
             || (c[7:chxo_pkg::IPR_IDX_W] ==
                 chxo_pkg::CMD_INT_PRESET[7:chxo_pkg::IPR_IDX_W]);
  endfunction : known_cmd

  // Inbound word is built at the scan that delivers the command, so it is
  // read right after that same scan; an error shows once, then the prior data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inbound <= {chxo_pkg::TAG_STATUS, 24'h00_0000};
    end else if (scan) begin
      if (!known_cmd(cmd)) begin
        inbound <= {chxo_pkg::TAG_ERROR, chxo_pkg::ERR_BAD_CMD};
      end else if (status[chxo_pkg::ST_POWER_UP] &&
                   cmd != chxo_pkg::CMD_RESET_CARD) begin
        inbound <= {chxo_pkg::TAG_ERROR, chxo_pkg::ERR_LOCKED};
      end else begin
        unique case (cmd)
          chxo_pkg::CMD_RET_STATUS: inbound <= ret_word(chxo_pkg::chxo_ret_status);
          chxo_pkg::CMD_RET_OUTS:   inbound <= ret_word(chxo_pkg::chxo_ret_outs);
          chxo_pkg::CMD_RET_COUNT:  inbound <= ret_word(chxo_pkg::chxo_ret_count);
          chxo_pkg::CMD_RET_RATE:   inbound <= ret_word(chxo_pkg::chxo_ret_rate);
          chxo_pkg::CMD_RET_DISC:   inbound <= ret_word(chxo_pkg::chxo_ret_disc);
          default:                  inbound <= ret_word(ret_sel);
        endcase
      end
    end
  end

  // ==========================================
  // Output and internal preset evaluation
  // Runs every cycle regardless of bus traffic, so a held host loses
  // only visibility, never control.
  assign run_ok = host_online ||
                  (keep_running_jumper && status[chxo_pkg::ST_LOADED]
                   && !status[chxo_pkg::ST_RELOAD]);

  always_comb begin
    for (int i = 0; i < chxo_pkg::NUM_OUT; i++) begin
      // Latch holds an output only while it is already on
      next_out[i] = (cmp_result(accum_count, out_preset[i], out_sense[i])
                     && out_enable[i])
                    || (latch_req[i] && field_out[i]);
    end
    for (int i = 0; i < chxo_pkg::NUM_IPR; i++) begin
      next_hit[i] = cmp_result(accum_count, int_preset[i], int_sense[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_out  <= 4'h0;
      preset_hit <= 8'h00;
    end else begin
      field_out  <= run_ok && !status[chxo_pkg::ST_POWER_UP] ? next_out : 4'h0;
      preset_hit <= next_hit;
    end
  end

endmodule : chxo_top

`default_nettype wire

//--- tb/chxo_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module chxo_top_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Run conditions and outputs
  input wire logic        host_online,
  input wire logic        keep_running_jumper,
  input wire logic [3:0]  field_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Scan exchange
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("second write answer");
  property p_one_take; s_axi_awready |=> !s_axi_awready; endproperty
  a_one_take: assert property (p_one_take) else $error("address taken twice");
  property p_busy_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("scan taken while busy");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("inbound word dropped");
  property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_once: assert property (p_rd_once) else $error("second read answer");
  // ==========================================
  // Outputs
  property p_offline_dark; !host_online && !keep_running_jumper |=> field_out == 4'h0; endproperty
  a_offline_dark: assert property (p_offline_dark) else $error("output on with host gone");
  property p_reset_clear;
    $rose(aresetn) |-> field_out == 4'h0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state survived reset");
endmodule : chxo_top_assertions

bind chxo_top chxo_top_assertions chxo_top_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .host_online(host_online), .keep_running_jumper(keep_running_jumper), .field_out(field_out));
`default_nettype wire

//--- tb/chxo_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Real hosts space scans 6 ms apart; scaled down to keep runs short
module chxo_host_model #(parameter int SCAN_GAP = 20) (
  // Clock
  input wire logic         aclk,
  // Write channels
  output logic [3:0]       s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input wire logic         s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [3:0]       s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // ==========================================
  // One outbound word per scan, selector in the low byte
  task automatic scan_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (SCAN_GAP) @(posedge aclk);
  endtask : scan_write
  // ==========================================
  // Inbound word; rready stands from the request until the answer
  task automatic scan_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : scan_read
endmodule : chxo_host_model
`default_nettype wire

//--- tb/chxo_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module chxo_tb_top;
  // ==========================================
  // Wiring
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, power_lost, host_online, jumper;
  logic [3:0]  awaddr, araddr, wstrb, field_out;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] wdata, rdata, rd;
  logic [23:0] accum_count, rate_value, row;
  logic [7:0]  exp_hit, preset_hit;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // Rows: count, output sense, enables, latches, expected outputs
  localparam logic [23:0] ROWS [8] = '{24'h23_F505, 24'h23_F515, 24'h23_F011, 24'h05_F011,
                                       24'h05_F000, 24'h05_0F0F, 24'h23_0220, 24'h23_F222};
  // Rows: command, expected tag, expected value
  localparam logic [39:0] RETS [8] = '{
    {chxo_pkg::CMD_RET_COUNT, chxo_pkg::TAG_COUNT, 24'h00_0023},
    {chxo_pkg::CMD_CONTINUE, chxo_pkg::TAG_COUNT, 24'h00_0023},
    {chxo_pkg::CMD_RET_RATE, chxo_pkg::TAG_RATE, 24'h00_1234},
    {8'h05, chxo_pkg::TAG_ERROR, chxo_pkg::ERR_BAD_CMD},
    {chxo_pkg::CMD_CONTINUE, chxo_pkg::TAG_RATE, 24'h00_1234},
    {chxo_pkg::CMD_RET_OUTS, chxo_pkg::TAG_OUTS, 24'h00_0F02},
    {chxo_pkg::CMD_RET_DISC, chxo_pkg::TAG_DISC, 24'h00_0088},
    {chxo_pkg::CMD_RET_STATUS, chxo_pkg::TAG_STATUS, 24'h00_0002}};

  chxo_top chxo_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .accum_count(accum_count), .rate_value(rate_value), .power_lost(power_lost),
    .host_online(host_online), .keep_running_jumper(jumper), .field_out(field_out),
    .preset_hit(preset_hit));
  chxo_host_model #(.SCAN_GAP(20)) chxo_host_model_inst (.aclk(aclk), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==========================================
  // Scan helpers
  task automatic cmd(input logic [7:0] c, input logic [23:0] p);
    chxo_host_model_inst.scan_write(chxo_pkg::ADDR_OUTBOUND, {p, c}, resp);
  endtask : cmd
  task automatic rdc(input logic [3:0] a, input logic [31:0] ex, input string nm);
    chxo_host_model_inst.scan_read(a, rd, resp);
    `CHK(nm, ex, rd)
  endtask : rdc
  task automatic inb(input logic [7:0] tg, input logic [23:0] v);
    rdc(chxo_pkg::ADDR_INBOUND, {tg, v}, "inbound");
  endtask : inb
  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Whole run needs about 1200 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    power_lost = 1'b0;
    host_online = 1'b1;
    jumper = 1'b0;
    accum_count = 24'h00_0023;
    rate_value = 24'h00_1234;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    inb(chxo_pkg::TAG_STATUS, 24'h00_0000);
    chxo_host_model_inst.scan_write(chxo_pkg::ADDR_STATUS, 32'h0000_0000, resp);
    for (int i = 0; i < 8; i++) cmd(chxo_pkg::CMD_INT_PRESET + 8'(i), 24'(10 * i));
    for (int s = 0; s < 2; s++) begin
      cmd(chxo_pkg::CMD_SENSE, {12'h000, {8{s[0]}}, 4'h0});
      for (int i = 0; i < 8; i++) exp_hit[i] = s ? (35 >= 10 * i) : (35 < 10 * i);
      `CHK("preset_hit", exp_hit, preset_hit)
    end
    for (int i = 0; i < 4; i++) cmd(chxo_pkg::CMD_OUT_PRESET + 8'(i), 24'h00_0014);
    for (int r = 0; r < 8; r++) begin
      row = ROWS[r];
      accum_count <= {16'h0000, row[23:16]};
      cmd(chxo_pkg::CMD_SENSE, {20'h0_0000, row[15:12]});
      cmd(chxo_pkg::CMD_DISCRETE, {14'h0000, row[7:4], row[11:8], 2'b00});
      `CHK("field_out", row[3:0], field_out)
    end
    rdc(chxo_pkg::ADDR_OUTPUTS, 32'h0000_0F02, "outputs");
    for (int k = 0; k < 8; k++) begin
      cmd(RETS[k][39:32], 24'h00_0000);
      inb(RETS[k][31:24], RETS[k][23:0]);
    end
    @(posedge aclk) power_lost <= 1'b1;
    @(posedge aclk) power_lost <= 1'b0;
    cmd(chxo_pkg::CMD_CONTINUE, 24'h00_0000);
    inb(chxo_pkg::TAG_STATUS, 24'h00_0001);
    host_online <= 1'b0;
    jumper <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("field_out", 4'h0, field_out)
    cmd(chxo_pkg::CMD_OUT_PRESET, 24'h00_0014);
    `CHK("field_out", 4'h0, field_out)
    cmd(chxo_pkg::CMD_INT_PRESET, 24'h00_0000);
    `CHK("field_out", 4'h2, field_out)
    jumper <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("field_out", 4'h0, field_out)
    host_online <= 1'b1;
    chxo_host_model_inst.scan_write(chxo_pkg::ADDR_INBOUND, 32'hFFFF_FFFF, resp);
    `CHK("bresp", chxo_pkg::RESP_SLVERR, resp)
    rdc(chxo_pkg::ADDR_OUTBOUND, {24'h00_0000, chxo_pkg::CMD_INT_PRESET}, "outbound");
    cmd(chxo_pkg::CMD_RESET_CARD, 24'h00_0000);
    cmd(chxo_pkg::CMD_RET_COUNT, 24'h00_0000);
    inb(chxo_pkg::TAG_ERROR, chxo_pkg::ERR_LOCKED);
    chxo_host_model_inst.scan_write(chxo_pkg::ADDR_STATUS, 32'h0000_0000, resp);
    `CHK("preset_hit", 8'h00, preset_hit)
    `CHK("field_out", 4'h0, field_out)
    cmd(chxo_pkg::CMD_RET_COUNT, 24'h00_0000);
    inb(chxo_pkg::TAG_COUNT, 24'h00_0023);
    give_verdict();
  end
endmodule : chxo_tb_top
`default_nettype wire
